// >>> shared/bdm_pkg.sv
// Shared constants and types for the banked data memory addressing block
package bdm_pkg;

	////////////////////////////////////////////////////////////////////////
	// Memory geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int PTR_COUNT = 3;
	localparam int BANK_COUNT = 16;
	localparam int BANK_BYTES = 256;
	localparam int MEM_BYTES = BANK_COUNT * BANK_BYTES;
	localparam logic [3:0] IMPL_BANKS = 4'h6;
	localparam logic [3:0] SPECIAL_BANK = 4'hF;
	localparam logic [3:0] LOW_BANK = 4'h0;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [3:0] BANK_SELECT_RESET = 4'h0;
	localparam logic [11:0] POINTER_RESET = 12'h000;

	////////////////////////////////////////////////////////////////////////
	// Special function locations in the top bank
	localparam logic [11:0] ADDR_BANK_SELECT = 12'hFE0;
	localparam logic [11:0] ALIAS_BASE = 12'hFEF;
	localparam logic [11:0] ALIAS_LOWEST = 12'hFD7;
	localparam logic [2:0] OFS_PLAIN = 3'h0;
	localparam logic [2:0] OFS_INC_AFTER = 3'h1;
	localparam logic [2:0] OFS_DEC_AFTER = 3'h2;
	localparam logic [2:0] OFS_INC_BEFORE = 3'h3;
	localparam logic [2:0] OFS_ADD_WORKING = 3'h4;
	localparam logic [2:0] OFS_HIGH = 3'h5;
	localparam logic [2:0] OFS_LOW = 3'h6;

	////////////////////////////////////////////////////////////////////////
	// Avalon register offsets (byte addresses)
	localparam logic [4:0] AVS_BANK_SELECT = 5'h00;
	localparam logic [4:0] AVS_POINTER0 = 5'h04;
	localparam logic [4:0] AVS_POINTER1 = 5'h08;
	localparam logic [4:0] AVS_POINTER2 = 5'h0C;
	localparam logic [4:0] AVS_STATUS = 5'h10;

	////////////////////////////////////////////////////////////////////////
	// Core operation kinds
	typedef enum logic [2:0]
	{
		OP_DIRECT = 3'b001,
		OP_FULL = 3'b010,
		OP_LOAD_BANK = 3'b100
	} bdm_op_type;

endpackage

// >>> rtl/bdm_pointer.sv
// One 12-bit indirect address pointer with byte loads and stepping
`timescale 1ns/1ps
`default_nettype none
module bdm_pointer
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic loadLow,
	input wire logic loadHigh,
	input wire logic [7:0] byteData,
	input wire logic loadFull,
	input wire logic [11:0] fullData,
	input wire logic stepUp,
	input wire logic stepDown,
	output logic [11:0] pointerValue
);
	logic [11:0] pointer_reg;
	logic [11:0] pointer_next;

	always_comb
	begin
		pointer_next = pointer_reg;
		// Steps carry across all twelve bits
		if (stepUp)
			pointer_next = pointer_reg + 12'h001;
		else if (stepDown)
			pointer_next = pointer_reg - 12'h001;
		// Explicit writes override a step on the bits they load
		if (loadFull)
			pointer_next = fullData;
		if (loadLow)
			pointer_next[7:0] = byteData;
		if (loadHigh)
			pointer_next[11:8] = byteData[3:0];
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			pointer_reg <= bdm_pkg::POINTER_RESET;
		else
			pointer_reg <= pointer_next;
	end

	assign pointerValue = pointer_reg;
endmodule
`default_nettype wire

// >>> rtl/bdm_ram.sv
// Static data RAM with unimplemented banks reading zero
`timescale 1ns/1ps
`default_nettype none
module bdm_ram
(
	input wire logic clk_sys,
	input wire logic wrEn,
	input wire logic [11:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic implemented
);
	logic [7:0] mem [0:bdm_pkg::MEM_BYTES-1];

	// Only low banks and the top bank exist; the rest is a hole
	assign implemented = (addr[11:8] < bdm_pkg::IMPL_BANKS) || (addr[11:8] == bdm_pkg::SPECIAL_BANK);
	assign rdata = implemented ? mem[addr] : 8'h00;

	// No reset: contents are undefined after power-up, like real SRAM
	always_ff @(posedge clk_sys)
	begin
		if (wrEn && implemented)
			mem[addr] <= wdata;
	end
endmodule
`default_nettype wire

// >>> rtl/bdm_addr_unit.sv
// Data memory address generation: banking, access bank, indirect pointers
// Function
// - Access bank: bank 15 top, bank 0 bottom
// - Access bit picks bank select or access bank
// - Low access area continues into special area
// - Special registers reachable without changing bank
// - Sixteen banks for direct addressing
// - Bank select bits form address upper nibble
// - Bank select upper nibble reads zero
// - Load-bank-literal operation sets bank select
// - Unimplemented bank reads zero, drops writes
// - Status flags still updated by core
// - 256-byte banks built from static RAM
// - File-to-file move uses full addresses
// - Indirect alias accesses pointed-to location
// - Pointers hold full twelve-bit addresses
// - Indirect read of alias returns zero
// - Indirect write of alias does nothing
// - Five aliases per pointer select pointer action
// - Steps carry across twelve bits, no flags
// - Offset mode adds signed working value
// - Write to pointer byte beats auto-step
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bdm_addr_unit
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [4:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWritedata,
	input wire logic [3:0] avsByteenable,
	output logic [31:0] avsReaddata,
	output logic avsWaitrequest,
	input wire logic coreValid,
	input wire logic coreWrite,
	input wire logic [2:0] coreOp,
	input wire logic [7:0] coreFileAddr,
	input wire logic coreAccessBit,
	input wire logic [11:0] coreFullAddr,
	input wire logic [7:0] coreLiteral,
	input wire logic [7:0] coreWdata,
	input wire logic [7:0] coreWorking,
	output logic [7:0] coreRdata,
	output logic coreDone,
	output logic coreVirtualHit,
	output logic coreUnimplHit,
	output logic [11:0] coreAddrOut
);
	////////////////////////////////////////////////////////////////////////
	// Alias decode: {hit, group[1:0], offset[2:0]}
	function automatic logic [5:0] decodeAlias(input logic [11:0] a);
		logic [11:0] d;
		d = bdm_pkg::ALIAS_BASE - a;
		decodeAlias = 6'h00;
		if (a >= bdm_pkg::ALIAS_LOWEST && a <= bdm_pkg::ALIAS_BASE && d[2:0] <= bdm_pkg::OFS_LOW && d[4:3] != 2'h3)
			decodeAlias = {1'b1, d[4:3], d[2:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State
	logic [3:0] bankSelect_reg;
	logic [3:0] bankSelect_next;
	logic [7:0] coreRdata_reg;
	logic [7:0] coreRdata_next;
	logic coreDone_reg;
	logic coreDone_next;
	logic coreVirtualHit_reg;
	logic coreVirtualHit_next;
	logic coreUnimplHit_reg;
	logic coreUnimplHit_next;
	logic [11:0] coreAddrOut_reg;
	logic [11:0] coreAddrOut_next;
	logic [31:0] avsReaddata_reg;
	logic [31:0] avsReaddata_next;
	logic avsWaitrequest_reg;
	logic avsWaitrequest_next;

	////////////////////////////////////////////////////////////////////////
	// Address resolution
	logic coreAccess;
	logic [11:0] directAddr;
	logic [11:0] namedAddr;
	logic [5:0] namedDec;
	logic isIndirect;
	logic [1:0] grp;
	logic [2:0] ofs;
	logic [11:0] ptrSel;
	logic [11:0] effAddr;
	logic [5:0] effDec;
	logic targetVirtual;
	logic [11:0] targetAddr;
	logic [5:0] targetDec;
	logic hitBankSelect;
	logic hitPtrHigh;
	logic hitPtrLow;
	logic writeEn;
	logic [11:0] pointerValue [0:bdm_pkg::PTR_COUNT-1];
	logic [7:0] ramRdata;
	logic ramImpl;
	logic avsDone;

	assign coreAccess = coreValid && (coreOp != bdm_pkg::OP_LOAD_BANK);

	always_comb
	begin
		// Access bit low forces the access bank: low half of bank 0, then the special area
		if (!coreAccessBit)
			directAddr = (coreFileAddr < bdm_pkg::ACCESS_SPLIT) ? {bdm_pkg::LOW_BANK, coreFileAddr}
				: {bdm_pkg::SPECIAL_BANK, coreFileAddr};
		else
			directAddr = {bankSelect_reg, coreFileAddr};
		namedAddr = (coreOp == bdm_pkg::OP_FULL) ? coreFullAddr : directAddr;
	end

	always_comb
	begin
		namedDec = decodeAlias(namedAddr);
		grp = namedDec[4:3];
		ofs = namedDec[2:0];
		isIndirect = namedDec[5] && (ofs <= bdm_pkg::OFS_ADD_WORKING);
		ptrSel = pointerValue[grp];
		case (ofs)
			bdm_pkg::OFS_INC_BEFORE: effAddr = ptrSel + 12'h001;
			bdm_pkg::OFS_ADD_WORKING: effAddr = ptrSel + {{4{coreWorking[7]}}, coreWorking};
			default: effAddr = ptrSel;
		endcase
		effDec = decodeAlias(effAddr);
		// A pointer aimed at an indirect alias is a dead end, not a second indirection
		targetVirtual = isIndirect && effDec[5] && (effDec[2:0] <= bdm_pkg::OFS_ADD_WORKING);
		targetAddr = isIndirect ? effAddr : namedAddr;
	end

	always_comb
	begin
		targetDec = decodeAlias(targetAddr);
		hitBankSelect = (targetAddr == bdm_pkg::ADDR_BANK_SELECT);
		hitPtrHigh = targetDec[5] && (targetDec[2:0] == bdm_pkg::OFS_HIGH);
		hitPtrLow = targetDec[5] && (targetDec[2:0] == bdm_pkg::OFS_LOW);
		writeEn = coreAccess && coreWrite && !targetVirtual;
	end

	////////////////////////////////////////////////////////////////////////
	// Pointers
	genvar gi;
	generate
		for (gi = 0; gi < bdm_pkg::PTR_COUNT; gi++)
		begin : gPtr
			logic mine;
			logic stepUp;
			logic stepDown;
			logic loadFull;
			assign mine = coreAccess && isIndirect && (grp == 2'(gi));
			assign stepUp = mine && (ofs == bdm_pkg::OFS_INC_AFTER || ofs == bdm_pkg::OFS_INC_BEFORE);
			assign stepDown = mine && (ofs == bdm_pkg::OFS_DEC_AFTER);
			assign loadFull = avsWrite && !avsWaitrequest_reg && (avsAddress == bdm_pkg::AVS_POINTER0 + 5'(4 * gi))
				&& (avsByteenable[1:0] == 2'b11);
			bdm_pointer uPtr
			(
				.clk_sys(clk_sys),
				.srst(srst),
				.loadLow(writeEn && hitPtrLow && targetDec[4:3] == 2'(gi)),
				.loadHigh(writeEn && hitPtrHigh && targetDec[4:3] == 2'(gi)),
				.byteData(coreWdata),
				.loadFull(loadFull),
				.fullData(avsWritedata[11:0]),
				.stepUp(stepUp),
				.stepDown(stepDown),
				.pointerValue(pointerValue[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Data RAM
	bdm_ram uRam
	(
		.clk_sys(clk_sys),
		.wrEn(writeEn && !hitBankSelect && !hitPtrHigh && !hitPtrLow),
		.addr(targetAddr),
		.wdata(coreWdata),
		.rdata(ramRdata),
		.implemented(ramImpl)
	);

	////////////////////////////////////////////////////////////////////////
	// Bank select
	always_comb
	begin
		bankSelect_next = bankSelect_reg;
		if (avsWrite && !avsWaitrequest_reg && avsAddress == bdm_pkg::AVS_BANK_SELECT && avsByteenable[0])
			bankSelect_next = avsWritedata[3:0];
		// Core wins a same-cycle clash: it is the program's own view of the bank
		if (writeEn && hitBankSelect)
			bankSelect_next = coreWdata[3:0];
		if (coreValid && coreOp == bdm_pkg::OP_LOAD_BANK)
			bankSelect_next = coreLiteral[3:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Core answer
	always_comb
	begin
		coreDone_next = coreValid;
		coreAddrOut_next = coreValid ? targetAddr : coreAddrOut_reg;
		coreVirtualHit_next = coreVirtualHit_reg;
		coreUnimplHit_next = coreUnimplHit_reg;
		coreRdata_next = coreRdata_reg;
		if (coreAccess)
		begin
			coreVirtualHit_next = targetVirtual;
			coreUnimplHit_next = !ramImpl;
			if (targetVirtual)
				coreRdata_next = 8'h00;
			else if (hitBankSelect)
				coreRdata_next = {4'h0, bankSelect_reg};
			else if (hitPtrHigh)
				coreRdata_next = {4'h0, pointerValue[targetDec[4:3]][11:8]};
			else if (hitPtrLow)
				coreRdata_next = pointerValue[targetDec[4:3]][7:0];
			else
				coreRdata_next = ramRdata;
		end
		else if (coreValid)
			coreRdata_next = 8'h00;
		// Done still fires on a hole so the core updates its flags as usual
	end

	////////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle, then the answer
	assign avsDone = (avsRead || avsWrite) && !avsWaitrequest_reg;

	always_comb
	begin
		avsWaitrequest_next = !((avsRead || avsWrite) && avsWaitrequest_reg);
		avsReaddata_next = avsReaddata_reg;
		if (avsRead && avsWaitrequest_reg)
		begin
			case (avsAddress)
				bdm_pkg::AVS_BANK_SELECT: avsReaddata_next = {28'h000_0000, bankSelect_reg};
				bdm_pkg::AVS_POINTER0: avsReaddata_next = {20'h0_0000, pointerValue[0]};
				bdm_pkg::AVS_POINTER1: avsReaddata_next = {20'h0_0000, pointerValue[1]};
				bdm_pkg::AVS_POINTER2: avsReaddata_next = {20'h0_0000, pointerValue[2]};
				bdm_pkg::AVS_STATUS: avsReaddata_next = {30'h0000_0000, coreUnimplHit_reg, coreVirtualHit_reg};
				default: avsReaddata_next = 32'h0000_0000;
			endcase
		end
		else if (avsDone)
			avsReaddata_next = avsReaddata_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			bankSelect_reg <= bdm_pkg::BANK_SELECT_RESET;
			coreRdata_reg <= 8'h00;
			coreDone_reg <= 1'b0;
			coreVirtualHit_reg <= 1'b0;
			coreUnimplHit_reg <= 1'b0;
			coreAddrOut_reg <= 12'h000;
			avsReaddata_reg <= 32'h0000_0000;
			avsWaitrequest_reg <= 1'b1;
		end
		else
		begin
			bankSelect_reg <= bankSelect_next;
			coreRdata_reg <= coreRdata_next;
			coreDone_reg <= coreDone_next;
			coreVirtualHit_reg <= coreVirtualHit_next;
			coreUnimplHit_reg <= coreUnimplHit_next;
			coreAddrOut_reg <= coreAddrOut_next;
			avsReaddata_reg <= avsReaddata_next;
			avsWaitrequest_reg <= avsWaitrequest_next;
		end
	end

	assign avsReaddata = avsReaddata_reg;
	assign avsWaitrequest = avsWaitrequest_reg;
	assign coreRdata = coreRdata_reg;
	assign coreDone = coreDone_reg;
	assign coreVirtualHit = coreVirtualHit_reg;
	assign coreUnimplHit = coreUnimplHit_reg;
	assign coreAddrOut = coreAddrOut_reg;
endmodule
`default_nettype wire

// >>> bench/bdm_addr_unit_assertions.sv
// Port-level checks for the address unit, bound to its top
`timescale 1ns/1ps
`default_nettype none
module bdm_addr_unit_assertions
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [4:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsReaddata,
	input wire logic avsWaitrequest,
	input wire logic coreValid,
	input wire logic coreWrite,
	input wire logic [2:0] coreOp,
	input wire logic [7:0] coreFileAddr,
	input wire logic coreAccessBit,
	input wire logic [11:0] coreFullAddr,
	input wire logic [7:0] coreRdata,
	input wire logic coreDone,
	input wire logic coreVirtualHit,
	input wire logic coreUnimplHit,
	input wire logic [11:0] coreAddrOut
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////////////
	sequence s_avs_req;
		(avsRead || avsWrite) && avsWaitrequest;
	endsequence
	sequence s_avs_rd;
		avsRead && avsWaitrequest;
	endsequence
	sequence s_avs_answer;
		!avsWaitrequest ##1 avsWaitrequest;
	endsequence
	sequence s_acc_direct;
		coreValid && coreOp == bdm_pkg::OP_DIRECT && !coreAccessBit;
	endsequence
	sequence s_hole_read;
		coreValid && !coreWrite ##1 (coreUnimplHit || coreVirtualHit);
	endsequence
	////////////////////////////////////////////////////////////////////////
	a_wait_answer: assert property (s_avs_req |=> s_avs_answer) else $error("waitrequest answer wrong");
	a_bank_upper: assert property (s_avs_rd ##0 avsAddress == bdm_pkg::AVS_BANK_SELECT
		|=> avsReaddata[31:4] == 28'h000_0000) else $error("bank select upper bits not zero");
	a_unmapped_zero: assert property (s_avs_rd ##0 avsAddress > bdm_pkg::AVS_STATUS
		|=> avsReaddata == 32'h0000_0000) else $error("unmapped read not zero");
	a_core_done: assert property (coreValid |=> coreDone) else $error("no done after request");
	a_done_idle: assert property (!coreValid |=> !coreDone) else $error("done without request");
	a_access_low: assert property (s_acc_direct ##0 !coreFileAddr[7]
		|=> coreAddrOut == {bdm_pkg::LOW_BANK, $past(coreFileAddr)}) else $error("access low address wrong");
	a_access_high: assert property (s_acc_direct ##0 coreFileAddr[7]
		&& (coreFileAddr < 8'hD7 || coreFileAddr > 8'hEF)
		|=> coreAddrOut == {bdm_pkg::SPECIAL_BANK, $past(coreFileAddr)}) else $error("access high address wrong");
	a_full_move: assert property (coreValid && coreOp == bdm_pkg::OP_FULL
		&& (coreFullAddr < bdm_pkg::ALIAS_LOWEST || coreFullAddr > bdm_pkg::ALIAS_BASE)
		|=> coreAddrOut == $past(coreFullAddr)) else $error("full address not used");
	// A bank load moves the address out but leaves the flags alone
	a_unimpl_flag: assert property (coreDone && !coreVirtualHit && $past(coreOp) != bdm_pkg::OP_LOAD_BANK
		|-> coreUnimplHit == (coreAddrOut[11:8] >= bdm_pkg::IMPL_BANKS
		&& coreAddrOut[11:8] != bdm_pkg::SPECIAL_BANK)) else $error("unimplemented flag wrong");
	a_hole_zero: assert property (s_hole_read |-> coreRdata == 8'h00) else $error("hole read not zero");
endmodule
bind bdm_addr_unit bdm_addr_unit_assertions u_chk (.clk_sys, .srst, .avsAddress, .avsRead, .avsWrite, .avsReaddata,
	.avsWaitrequest, .coreValid, .coreWrite, .coreOp, .coreFileAddr, .coreAccessBit, .coreFullAddr, .coreRdata,
	.coreDone, .coreVirtualHit, .coreUnimplHit, .coreAddrOut);
`default_nettype wire

// >>> bench/bdm_core_model.sv
// Core decoder model issuing one-cycle requests to the address unit
`timescale 1ns/1ps
`default_nettype none
module bdm_core_model
(
	input wire logic clk_sys,
	input wire logic coreDone,
	output logic coreValid,
	output logic coreWrite,
	output logic [2:0] coreOp,
	output logic [7:0] coreFileAddr,
	output logic coreAccessBit,
	output logic [11:0] coreFullAddr,
	output logic [7:0] coreLiteral,
	output logic [7:0] coreWdata,
	output logic [7:0] coreWorking
);
	initial
	begin
		coreValid = 1'b0;
		coreWrite = 1'b0;
		coreOp = 3'b000;
		coreFileAddr = 8'h00;
		coreAccessBit = 1'b0;
		coreFullAddr = 12'h000;
		coreLiteral = 8'h00;
		coreWdata = 8'h00;
		coreWorking = 8'h00;
	end
	// Bit 8 of a is the access bit, low byte is file address or literal
	task issue(input logic [2:0] op, input logic wr, input logic [11:0] a, input logic [7:0] wd, input logic [7:0] w,
		output logic ok);
		@(posedge clk_sys);
		coreValid <= 1'b1;
		coreWrite <= wr;
		coreOp <= op;
		coreFileAddr <= a[7:0];
		coreAccessBit <= a[8];
		coreFullAddr <= a;
		coreLiteral <= a[7:0];
		coreWdata <= wd;
		coreWorking <= w;
		@(posedge clk_sys);
		coreValid <= 1'b0;
		// Stale fields inverted so nothing leans on held values
		coreFileAddr <= ~a[7:0];
		coreFullAddr <= ~a;
		coreWdata <= ~wd;
		coreWorking <= ~w;
		#1 ok = (coreDone === 1'b1);
	endtask
endmodule
`default_nettype wire

// >>> bench/test_banked_data_memory_addressing.sv
// Self-checking bench for the banked address unit
`timescale 1ns/1ps
`default_nettype none
module test_banked_data_memory_addressing;
	logic clk_sys, srst, avsRead, avsWrite, avsWaitrequest, coreValid, coreWrite, coreAccessBit;
	logic coreDone, coreVirtualHit, coreUnimplHit, ok;
	logic [4:0] avsAddress;
	logic [3:0] avsByteenable, b;
	logic [31:0] avsWritedata, avsReaddata, rdat, r;
	logic [2:0] coreOp;
	logic [7:0] coreFileAddr, coreLiteral, coreWdata, coreWorking, coreRdata, fa, d, wk;
	logic [11:0] coreFullAddr, coreAddrOut, p;
	logic [23:0] e;
	int err_count = 0;
	int checked = 0;
	bdm_addr_unit dut (.clk_sys, .srst, .avsAddress, .avsRead, .avsWrite, .avsWritedata, .avsByteenable, .avsReaddata,
		.avsWaitrequest, .coreValid, .coreWrite, .coreOp, .coreFileAddr, .coreAccessBit, .coreFullAddr, .coreLiteral,
		.coreWdata, .coreWorking, .coreRdata, .coreDone, .coreVirtualHit, .coreUnimplHit, .coreAddrOut);
	bdm_core_model core (.clk_sys, .coreDone, .coreValid, .coreWrite, .coreOp, .coreFileAddr, .coreAccessBit,
		.coreFullAddr, .coreLiteral, .coreWdata, .coreWorking);
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////
	task complete_run;
		if (err_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x)
		begin
			$display("BAD %s expected %h seen %h", n, x, g);
			err_count++;
		end
	endtask
	task avs(input logic wr, input logic [4:0] a, input logic [31:0] dat, input logic [3:0] be);
		int n;
		@(posedge clk_sys);
		avsWrite <= wr;
		avsRead <= !wr;
		avsAddress <= a;
		avsWritedata <= dat;
		avsByteenable <= be;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (avsWaitrequest !== 1'b0 && n < 20);
		rdat = avsReaddata;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		chk("avs answer", 32'h0000_0001, 32'(n < 20));
	endtask
	task cx(input logic [2:0] op, input logic wr, input logic [11:0] a, input logic [7:0] wd);
		core.issue(op, wr, a, wd, wk, ok);
		chk("core done", 32'h0000_0001, 32'(ok));
	endtask
	// Address used and pointer left behind, per alias kind
	function automatic logic [23:0] ind_exp(input int m, input logic [11:0] q, input logic [7:0] w);
		case (m)
			1: return {q, q + 12'h001};
			2: return {q, q - 12'h001};
			3: return {q + 12'h001, q + 12'h001};
			4: return {q + {{4{w[7]}}, w}, q};
			default: return {q, q};
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#(25 * 4000);
		err_count++;
		complete_run();
	end
	initial
	begin
		srst = 1'b1;
		{avsRead, avsWrite, avsAddress, avsWritedata, avsByteenable} = '0;
		wk = 8'h00;
		r = $urandom(38853);
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		#1 chk("wait idle", 32'h0000_0001, 32'(avsWaitrequest));
		avs(1'b0, bdm_pkg::AVS_POINTER0, 32'h0, 4'hF);
		chk("pointer reset", 32'h0000_0000, rdat);
		avs(1'b1, bdm_pkg::AVS_BANK_SELECT, 32'h0000_00FF, 4'h0);
		avs(1'b0, bdm_pkg::AVS_BANK_SELECT, 32'h0, 4'hF);
		chk("bank no enable", 32'h0000_0000, rdat);
		avs(1'b1, bdm_pkg::AVS_BANK_SELECT, 32'h0000_00FF, 4'hF);
		avs(1'b0, bdm_pkg::AVS_BANK_SELECT, 32'h0, 4'hF);
		chk("bank upper", 32'h0000_000F, rdat);
		avs(1'b1, 5'h14, 32'hFFFF_FFFF, 4'hF);
		avs(1'b0, 5'h14, 32'h0, 4'hF);
		chk("unmapped", 32'h0000_0000, rdat);
		// Banks 0..5 implemented, bank 9 a hole
		for (int i = 0; i < 7; i++)
		begin
			b = (i == 6) ? 4'h9 : 4'(i);
			cx(bdm_pkg::OP_LOAD_BANK, 1'b0, {4'h0, 4'($urandom), b}, 8'h00);
			avs(1'b0, bdm_pkg::AVS_BANK_SELECT, 32'h0, 4'hF);
			chk("bank", 32'(b), rdat);
			fa = 8'($urandom);
			d = 8'($urandom);
			cx(bdm_pkg::OP_DIRECT, 1'b1, {4'h1, fa}, d);
			cx(bdm_pkg::OP_DIRECT, 1'b0, {4'h1, fa}, 8'h00);
			chk("direct addr", 32'({b, fa}), 32'(coreAddrOut));
			chk("direct data", 32'((i == 6) ? 8'h00 : d), 32'(coreRdata));
			chk("unimpl", 32'(i == 6), 32'(coreUnimplHit));
		end
		// Access bank seam: last low location, first special location, bank select in place
		d = 8'($urandom);
		cx(bdm_pkg::OP_DIRECT, 1'b1, 12'h07F, d);
		cx(bdm_pkg::OP_LOAD_BANK, 1'b0, 12'h000, 8'h00);
		cx(bdm_pkg::OP_DIRECT, 1'b0, 12'h17F, 8'h00);
		chk("access low", 32'({12'h07F, d}), 32'({coreAddrOut, coreRdata}));
		cx(bdm_pkg::OP_DIRECT, 1'b1, 12'h080, ~d);
		cx(bdm_pkg::OP_FULL, 1'b0, 12'hF80, 8'h00);
		chk("access high", 32'({12'hF80, ~d}), 32'({coreAddrOut, coreRdata}));
		cx(bdm_pkg::OP_DIRECT, 1'b1, 12'h0E0, 8'hF3);
		cx(bdm_pkg::OP_DIRECT, 1'b0, 12'h0E0, 8'h00);
		chk("bank via access", 32'h0000_0003, 32'(coreRdata));
		// Every indirect alias kind of pointer 1, with carry and borrow corners
		for (int m = 0; m < 5; m++)
		begin
			p = {4'(1 + $urandom_range(3)), (m == 2) ? 8'h00 : (m == 4) ? 8'($urandom) : 8'hFF};
			wk = 8'($urandom);
			e = ind_exp(m, p, wk);
			avs(1'b1, bdm_pkg::AVS_POINTER1, 32'(p), 4'hF);
			cx(bdm_pkg::OP_DIRECT, 1'b0, {4'h0, 8'hE7 - 8'(m)}, 8'h00);
			chk("alias addr", 32'(e[23:12]), 32'(coreAddrOut));
			avs(1'b0, bdm_pkg::AVS_POINTER1, 32'h0, 4'hF);
			chk("alias pointer", 32'(e[11:0]), rdat);
		end
		// Pointer 2 aimed at the plain alias of pointer 0
		avs(1'b1, bdm_pkg::AVS_POINTER2, 32'h0000_0FEF, 4'hF);
		cx(bdm_pkg::OP_DIRECT, 1'b0, 12'h0DF, 8'h00);
		chk("virtual read", 32'h0000_0100, 32'({coreVirtualHit, coreRdata}));
		avs(1'b0, bdm_pkg::AVS_STATUS, 32'h0, 4'hF);
		chk("status", 32'h0000_0001, rdat & 32'h0000_0001);
		cx(bdm_pkg::OP_DIRECT, 1'b1, 12'h0DF, 8'($urandom));
		avs(1'b0, bdm_pkg::AVS_POINTER2, 32'h0, 4'hF);
		chk("virtual write", 32'h0000_1FEF, {19'h0, coreVirtualHit, rdat[11:0]});
		// Pointer 0 aimed at its own low byte, written through post-increment
		d = 8'($urandom);
		avs(1'b1, bdm_pkg::AVS_POINTER0, 32'h0000_0FE9, 4'hF);
		cx(bdm_pkg::OP_DIRECT, 1'b1, 12'h0EE, d);
		avs(1'b0, bdm_pkg::AVS_POINTER0, 32'h0, 4'hF);
		chk("write beats step", 32'({4'hF, d}), rdat);
		d = 8'($urandom);
		cx(bdm_pkg::OP_FULL, 1'b1, 12'h2A5, d);
		cx(bdm_pkg::OP_FULL, 1'b0, 12'h2A5, 8'h00);
		chk("full move", 32'({12'h2A5, d}), 32'({coreAddrOut, coreRdata}));
		complete_run();
	end
endmodule
`default_nettype wire
